// File: src/rheo_pkg.sv
// Shared constants, command codes and carrier types of the rheostat block
package rheo_pkg;
   // ***********************************************************
   // Widths and wiper constants
   // ***********************************************************
   localparam int         FRAME_BITS = 16;
   localparam int         CODE_BITS  = 10;
   localparam int         TAPS       = 1024;
   localparam int         ADDR_BITS  = 6;
   localparam int         CNT_BITS   = 5;
   localparam logic [9:0] MIDSCALE   = 10'h200;
   localparam logic [4:0] FRAME_LEN  = 5'h10;
   localparam logic [4:0] CNT_ONE    = 5'h01;

   // ***********************************************************
   // Memory map
   // ***********************************************************
   localparam logic [5:0] ADDR_TOL_SIGN_INT = 6'h39;
   localparam logic [5:0] ADDR_TOL_FRACTION = 6'h3A;
   localparam logic [5:0] FUSE_SLOTS        = 6'h32;
   localparam logic [5:0] PTR_NONE          = 6'h00;
   localparam logic [5:0] PTR_STEP          = 6'h01;
   localparam int         TOL_SIGN_BIT      = 7;

   // ***********************************************************
   // Commands and control bits
   // ***********************************************************
   localparam logic [3:0] CMD_NOP        = 4'h0;
   localparam logic [3:0] CMD_WR_WIPER   = 4'h1;
   localparam logic [3:0] CMD_RD_WIPER   = 4'h2;
   localparam logic [3:0] CMD_STORE      = 4'h3;
   localparam logic [3:0] CMD_SW_RESET   = 4'h4;
   localparam logic [3:0] CMD_RD_MEM     = 4'h5;
   localparam logic [3:0] CMD_RD_LASTPTR = 4'h6;
   localparam logic [3:0] CMD_WR_CTRL    = 4'h7;
   localparam logic [3:0] CMD_RD_CTRL    = 4'h8;
   localparam int         CTRL_PROG_EN   = 0;
   localparam int         CTRL_UNLOCK    = 1;
   localparam int         CTRL_PROG_OK   = 3;

   // ***********************************************************
   // Carrier types
   // ***********************************************************
   typedef struct packed {
      logic [1:0] pad;
      logic [3:0] cmd;
      logic [9:0] data;
   } frame_s;

   typedef struct packed {
      logic       re;
      logic       we;
      logic [5:0] addr;
      logic [9:0] wdata;
   } mem_req_s;

   typedef enum logic [3:0] {
      B_PRESET = 4'b0001,
      B_FETCH  = 4'b0010,
      B_LOAD   = 4'b0100,
      B_IDLE   = 4'b1000
   } boot_e;
endpackage

// File: src/fuse_memory.sv
// One-time fuse memory with factory tolerance words and registered read data
`timescale 1ns/1ps
module fuse_memory
   import rheo_pkg::*;
#(
   parameter logic [7:0] TOL_SIGN_INT = 8'h00,
   parameter logic [7:0] TOL_FRACTION = 8'h00
) (
   input  wire logic           clk_sys,
   input  wire logic           ce,
   input  wire mem_req_s       req,
   output logic [CODE_BITS-1:0] rdata_q,
   output logic [ADDR_BITS-1:0] last_ptr_q
);
   // Slot 0 is reserved; slots 1 to FUSE_SLOTS hold programmed codes
   logic [CODE_BITS-1:0] slot_q [FUSE_SLOTS+1];
   // Nonvolatile: survives reset, so no reset term
   logic [ADDR_BITS-1:0] ptr_q = PTR_NONE;

   wire sel_hi   = (req.addr == ADDR_TOL_SIGN_INT);
   wire sel_lo   = (req.addr == ADDR_TOL_FRACTION);
   wire slot_ok  = (req.addr != PTR_NONE) && (req.addr <= ptr_q);
   // Factory words are packed into the low byte; top two bits read zero
   wire [CODE_BITS-1:0] tol_hi = {2'h0, TOL_SIGN_INT};
   wire [CODE_BITS-1:0] tol_lo = {2'h0, TOL_FRACTION};
   wire [CODE_BITS-1:0] rd_mux = sel_hi  ? tol_hi :
                                 sel_lo  ? tol_lo :
                                 slot_ok ? slot_q[req.addr] : '0;
   // Writes only append to the next fresh slot, never the factory words
   wire wr_ok = req.we && (req.addr == ptr_q + PTR_STEP) && (req.addr <= FUSE_SLOTS);

   assign last_ptr_q = ptr_q;

   always_ff @(posedge clk_sys) begin
      if (ce && wr_ok) begin
         slot_q[req.addr] <= req.wdata;
         ptr_q            <= req.addr;
      end
      if (ce && req.re) begin
         rdata_q <= rd_mux;
      end
   end

   AST_TOL_HI_READ: assert property (@(posedge clk_sys) ce && req.re && sel_hi |=>
      rdata_q == tol_hi) else $error("Sign and integer word misread");
   AST_TOL_LO_READ: assert property (@(posedge clk_sys) ce && req.re && sel_lo |=>
      rdata_q == tol_lo) else $error("Fraction word misread");
endmodule // fuse_memory

// File: src/rheostat_core.sv
// Wiper code register, power-on restore and serial command decoder
//
// Summary of operation
// - Decode 10-bit wiper code to one tap
// - Tolerance is 16-bit sign magnitude, two words
// - Location 0x39: sign bit 7, integer 6:0
// - Location 0x3A: fraction, half down to 1/256
// - Tolerance words are read only
// - Power-up: midscale first, then last fuse value
// - Unprogrammed memory keeps midscale; locked wiper keeps its current code
// - Memory read answers in the next frame
`timescale 1ns/1ps
module rheostat_core
   import rheo_pkg::*;
#(
   parameter logic [7:0] TOL_SIGN_INT = 8'h00,
   parameter logic [7:0] TOL_FRACTION = 8'h00
) (
   input  wire logic                 clk_sys,
   input  wire logic                 reset,
   input  wire logic                 ce,
   input  wire logic                 sclk,
   input  wire logic                 sync_n,
   input  wire logic                 din,
   output logic                      sdo_o,
   output logic                      sdo_oe,
   output logic [CODE_BITS-1:0]      wiper_code,
   output logic [TAPS-1:0]           tap_sel,
   output logic                      boot_done
);
   // ***********************************************************
   // Helpers
   // ***********************************************************
   function automatic logic [TAPS-1:0] tap_decode(input logic [CODE_BITS-1:0] code);
      tap_decode = '0;
      tap_decode[code] = 1'b1;
   endfunction

   // ***********************************************************
   // State
   // ***********************************************************
   boot_e                 boot_q;
   logic [CODE_BITS-1:0]  wiper_q;
   logic [TAPS-1:0]       tap_q;
   logic [FRAME_BITS-1:0] rx_q;
   logic [FRAME_BITS-1:0] tx_q;
   logic [FRAME_BITS-1:0] resp_q;
   logic [CNT_BITS-1:0]   cnt_q;
   logic                  sclk_q;
   logic                  sync_q;
   logic                  rd_pend_q;
   logic                  prog_en_q;
   logic                  unlock_q;
   logic                  prog_ok_q;
   logic                  sdo_q;
   logic                  oe_q;
   logic [CODE_BITS-1:0]  mem_rdata;
   logic [ADDR_BITS-1:0]  last_ptr;
   mem_req_s              mem_req;

   // ***********************************************************
   // Frame decode
   // ***********************************************************
   frame_s rx_frame;
   assign rx_frame = rx_q;
   wire sclk_fall  = sclk_q && !sclk;
   wire sclk_rise  = !sclk_q && sclk;
   wire frame_beg  = sync_q && !sync_n;
   wire frame_end  = !sync_q && sync_n;
   wire idle       = (boot_q == B_IDLE);
   // Short or long frames are dropped; commands wait for the restore
   wire exec       = frame_end && (cnt_q == FRAME_LEN) && idle;
   wire cmd_wr     = exec && (rx_frame.cmd == CMD_WR_WIPER);
   wire cmd_store  = exec && (rx_frame.cmd == CMD_STORE);
   wire cmd_reset  = exec && (rx_frame.cmd == CMD_SW_RESET);
   wire cmd_rdmem  = exec && (rx_frame.cmd == CMD_RD_MEM);
   wire cmd_ctrl   = exec && (rx_frame.cmd == CMD_WR_CTRL);
   wire store_ok   = cmd_store && prog_en_q && (last_ptr < FUSE_SLOTS);
   wire boot_load  = (boot_q == B_LOAD) && (last_ptr != PTR_NONE);
   wire [CODE_BITS-1:0] ctrl_word = {6'h00, prog_ok_q, 1'b0, unlock_q, prog_en_q};
   wire [CODE_BITS-1:0] ptr_word  = {4'h0, last_ptr};

   // Default answer echoes the last frame, which keeps daisy chains working
   wire [FRAME_BITS-1:0] resp_d =
      !exec                            ? resp_q :
      (rx_frame.cmd == CMD_RD_WIPER)   ? {6'h00, wiper_q} :
      (rx_frame.cmd == CMD_RD_LASTPTR) ? {6'h00, ptr_word} :
      (rx_frame.cmd == CMD_RD_CTRL)    ? {6'h00, ctrl_word} : rx_q;

   // One read port: boot owns it until idle, then frames do
   assign mem_req.re    = (boot_q == B_FETCH) || cmd_rdmem;
   assign mem_req.we    = store_ok;
   assign mem_req.addr  = (boot_q == B_FETCH) ? last_ptr :
                          store_ok ? last_ptr + PTR_STEP : rx_frame.data[ADDR_BITS-1:0];
   assign mem_req.wdata = wiper_q;

   fuse_memory #(
      .TOL_SIGN_INT (TOL_SIGN_INT),
      .TOL_FRACTION (TOL_FRACTION)
   ) u_fuse (
      .clk_sys    (clk_sys),
      .ce         (ce),
      .req        (mem_req),
      .rdata_q    (mem_rdata),
      .last_ptr_q (last_ptr)
   );

   // ***********************************************************
   // Power-on restore
   // ***********************************************************
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         boot_q <= B_PRESET;
      end else if (ce) begin
         unique case (boot_q)
            B_PRESET: boot_q <= B_FETCH;
            B_FETCH:  boot_q <= B_LOAD;
            B_LOAD:   boot_q <= B_IDLE;
            B_IDLE:   boot_q <= cmd_reset ? B_PRESET : B_IDLE;
         endcase
      end
   end

   // ***********************************************************
   // Wiper register and control bits
   // ***********************************************************
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wiper_q <= MIDSCALE;
      end else if (ce) begin
         if (boot_q == B_PRESET) begin
            wiper_q <= MIDSCALE;
         end else if (boot_load) begin
            wiper_q <= mem_rdata;
         end else if (cmd_wr && unlock_q) begin
            wiper_q <= rx_frame.data;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         prog_en_q <= 1'b0;
         unlock_q  <= 1'b0;
         prog_ok_q <= 1'b0;
      end else if (ce) begin
         if (cmd_ctrl) begin
            prog_en_q <= rx_frame.data[CTRL_PROG_EN];
            unlock_q  <= rx_frame.data[CTRL_UNLOCK];
         end
         if (cmd_store) begin
            prog_ok_q <= store_ok;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tap_q <= tap_decode(MIDSCALE);
      end else if (ce) begin
         tap_q <= tap_decode(wiper_q);
      end
   end

   // ***********************************************************
   // Serial shift paths
   // ***********************************************************
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sclk_q    <= 1'b0;
         sync_q    <= 1'b1;
         cnt_q     <= '0;
         rx_q      <= '0;
         resp_q    <= '0;
         rd_pend_q <= 1'b0;
      end else if (ce) begin
         sclk_q    <= sclk;
         sync_q    <= sync_n;
         rd_pend_q <= cmd_rdmem;
         if (frame_beg) begin
            cnt_q <= '0;
         end else if (!sync_n && sclk_fall && cnt_q <= FRAME_LEN) begin
            rx_q  <= {rx_q[FRAME_BITS-2:0], din};
            cnt_q <= cnt_q + CNT_ONE;
         end
         // Memory data lands one cycle after the read is issued
         resp_q <= rd_pend_q ? {6'h00, mem_rdata} : resp_d;
      end
   end

   // Open drain: only ever pulls low, so a one releases the pin
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tx_q <= '0;
         sdo_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (ce) begin
         if (sync_n) begin
            oe_q <= 1'b0;
         end else if (sclk_rise) begin
            oe_q <= !tx_q[FRAME_BITS-1];
            tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0};
         end
         if (frame_beg) begin
            tx_q <= resp_q;
         end
      end
   end

   assign sdo_o      = sdo_q;
   assign sdo_oe     = oe_q;
   assign wiper_code = wiper_q;
   assign tap_sel    = tap_q;
   assign boot_done  = boot_q[3];

   // ***********************************************************
   // Checks
   // ***********************************************************
   sequence s_restore;
      (boot_q == B_FETCH) ##1 (boot_q == B_LOAD) ##1 (boot_q == B_IDLE);
   endsequence

   AST_TAP_ONEHOT: assert property (@(posedge clk_sys) disable iff (reset)
      $onehot(tap_q)) else $error("Tap select not one-hot");
   AST_TAP_FOLLOWS: assert property (@(posedge clk_sys) disable iff (reset || !ce)
      $stable(wiper_q) && ce ##1 $stable(wiper_q) |-> tap_q[wiper_q])
      else $error("Tap does not follow wiper code");
   AST_PRESET_MID: assert property (@(posedge clk_sys) disable iff (reset)
      boot_q == B_FETCH |-> wiper_q == MIDSCALE) else $error("Preset is not midscale");
   AST_RESTORE_SEQ: assert property (@(posedge clk_sys) disable iff (reset || !ce)
      boot_q == B_PRESET |=> s_restore) else $error("Restore sequence broken");
   AST_RESTORE_VAL: assert property (@(posedge clk_sys) disable iff (reset || !ce)
      boot_load |=> wiper_q == $past(mem_rdata)) else $error("Fuse value not restored");
   AST_UNPROG_MID: assert property (@(posedge clk_sys) disable iff (reset || !ce)
      boot_q == B_LOAD && last_ptr == PTR_NONE |=> wiper_q == MIDSCALE)
      else $error("Unprogrammed part left midscale");
   AST_LOCKED: assert property (@(posedge clk_sys) disable iff (reset || !ce)
      cmd_wr && !unlock_q |=> $stable(wiper_q)) else $error("Locked wiper changed");
   AST_TOL_RO: assert property (@(posedge clk_sys) disable iff (reset)
      mem_req.we |-> mem_req.addr <= FUSE_SLOTS) else $error("Write reached factory words");
   AST_MEMRD: assert property (@(posedge clk_sys) disable iff (reset || !ce)
      cmd_rdmem ##1 ce |=> resp_q == {6'h00, $past(mem_rdata)})
      else $error("Memory read not queued for next frame");
endmodule // rheostat_core

// File: sim/spi_host.sv
// Behavioural serial host that frames words and captures the device reply
`timescale 1ns/1ps
module spi_host
   import rheo_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sdo_pin,
   output logic             sclk,
   output logic             sync_n,
   output logic             din,
   output logic             resp_valid,
   output logic [15:0]      resp,
   output logic [7:0]       tol_byte
);
   // ***********************************************************
   // Frame engine, four system clocks per serial phase
   // ***********************************************************
   initial begin
      sclk       = 1'b0;
      sync_n     = 1'b1;
      din        = 1'b0;
      resp_valid = 1'b0;
      resp       = 16'h0000;
   end

   // Bits 9:8 of tolerance words carry nothing, so they are dropped
   assign tol_byte = resp[7:0];

   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // Command in the word, reply to the previous frame collected during this one
   task automatic xfer(input logic [15:0] w);
      int i;
      @(negedge clk_sys);
      sync_n = 1'b0;
      idle(4);
      for (i = 15; i >= 0; i--) begin
         sclk = 1'b1;
         din  = w[i];
         idle(4);
         resp[i] = sdo_pin;
         sclk    = 1'b0;
         idle(4);
      end
      sync_n     = 1'b1;
      din        = ~din;
      resp_valid = 1'b1;
      idle(1);
      resp_valid = 1'b0;
      idle(5);
   endtask
endmodule // spi_host

// File: sim/rheostat_wiper_preset_and_tolerance_tb.sv
// Self-checking bench for wiper preset, restore and tolerance readback
`timescale 1ns/1ps
module rheostat_wiper_preset_and_tolerance_tb
   import rheo_pkg::*;
;
   localparam logic [7:0] TSI = 8'h0A;
   localparam logic [7:0] TFR = 8'hB0;
   logic              clk_sys = 1'b0;
   logic              reset   = 1'b1;
   logic              ce      = 1'b1;
   logic              sclk, sync_n, din, sdo_o, sdo_oe, boot_done, resp_valid;
   logic [9:0]        wiper_code;
   logic [TAPS-1:0]   tap_sel;
   logic [15:0]       resp;
   logic [16:0]       exp_q[$];
   logic [16:0]       pending = 17'h00000;
   logic [16:0]       e;
   logic [31:0]       seed = 32'h0001810F;
   logic [9:0]        code, saved;
   int                fails = 0;
   int                num_checks = 0;
   wire logic         sdo_pin = sdo_oe ? sdo_o : 1'b1;

   always #4 clk_sys = ~clk_sys;

   rheostat_core #(.TOL_SIGN_INT(TSI), .TOL_FRACTION(TFR)) dut (
      .clk_sys(clk_sys), .reset(reset), .ce(ce), .sclk(sclk), .sync_n(sync_n),
      .din(din), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .wiper_code(wiper_code),
      .tap_sel(tap_sel), .boot_done(boot_done));

   spi_host host (
      .clk_sys(clk_sys), .sdo_pin(sdo_pin), .sclk(sclk), .sync_n(sync_n),
      .din(din), .resp_valid(resp_valid), .resp(resp), .tol_byte());

   // ***********************************************************
   // Helpers
   // ***********************************************************
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask

   // Reply of a frame shows up one frame later, hence the pending slot
   task automatic send(input logic [15:0] w, input logic [16:0] nxt);
      exp_q.push_back(pending);
      pending = nxt;
      host.xfer(w);
   endtask

   task automatic wiper_is(input logic [9:0] c);
      repeat (2) @(negedge clk_sys);
      chk({6'h00, wiper_code}, {6'h00, c});
      chk(16'(tap_sel === ({{(TAPS-1){1'b0}}, 1'b1} << c)), 16'h0001);
   endtask

   task automatic wait_boot();
      int n;
      for (n = 0; n < 200 && boot_done !== 1'b1; n++) @(negedge clk_sys);
      if (boot_done !== 1'b1) begin
         fails++;
         end_of_test();
      end
   endtask

   // ***********************************************************
   // Reply watcher
   // ***********************************************************
   always @(posedge clk_sys) begin
      if (resp_valid) begin
         e = exp_q.pop_front();
         if (e[16]) chk(resp, e[15:0]);
      end
   end

   // ***********************************************************
   // Main sequence
   // ***********************************************************
   initial begin
      repeat (14) @(negedge clk_sys);
      wiper_is(MIDSCALE);
      reset = 1'b0;
      wait_boot();
      wiper_is(MIDSCALE);
      send(16'h0555, {1'b1, 16'h0555});
      wiper_is(MIDSCALE);
      $display("test locked_preset done");
      send(16'h1C02, {1'b1, 16'h1C02});
      for (int k = 0; k < 5; k++) begin
         seed = xs(seed);
         code = seed[9:0];
         send({6'h01, code}, {1'b1, 6'h01, code});
         wiper_is(code);
      end
      send(16'h0800, {1'b1, 6'h00, code});
      send(16'h1439, {1'b1, 8'h00, TSI});
      send(16'h143A, {1'b1, 8'h00, TFR});
      chk({8'h00, host.tol_byte}, {8'h00, TSI});
      seed = xs(seed);
      saved = seed[9:0];
      send(16'h1C03, {1'b1, 16'h1C03});
      chk({8'h00, host.tol_byte}, {8'h00, TFR});
      $display("test tolerance done");
      send({6'h01, saved}, {1'b1, 6'h01, saved});
      send(16'h0C00, {1'b1, 16'h0C00});
      send(16'h2000, {1'b1, 16'h000B});
      send(16'h1800, {1'b1, 16'h0001});
      send(16'h1401, {1'b1, 6'h00, saved});
      send(16'h1439, {1'b1, 8'h00, TSI});
      send(16'h0411, {1'b1, 16'h0411});
      wiper_is(10'h011);
      // Frozen part ignores the frame and leaves the pin released
      ce = 1'b0;
      exp_q.push_back({1'b1, 16'hFFFF});
      host.xfer(16'h0555);
      ce = 1'b1;
      wiper_is(10'h011);
      $display("test clock_enable done");
      send(16'h1000, {1'b1, 16'h1000});
      repeat (4) @(negedge clk_sys);
      wait_boot();
      wiper_is(saved);
      send(16'h0800, {1'b1, 6'h00, saved});
      $display("test store_restore done");
      reset = 1'b1;
      wiper_is(MIDSCALE);
      reset = 1'b0;
      // Reply queued before the reset is lost with it
      pending = 17'h00000;
      wait_boot();
      wiper_is(saved);
      send(16'h0800, {1'b1, 6'h00, saved});
      send(16'h0000, 17'h00000);
      $display("test power_on_reset done");
      end_of_test();
   end
endmodule // rheostat_wiper_preset_and_tolerance_tb
